// [rtl/scci_pkg.sv]
// Purpose: Shared constants and types for the spline contour interpolator
// Assumes: 50 MHz REF_CLK
// Notes: Rate code equals ticks per point interval (code/5 ms over 0.2 ms)
package scci_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_US = 200;
	localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
	localparam int unsigned INTERP_MS = 5;
	localparam int unsigned INTERP_CYC = INTERP_MS * (CLK_HZ / 1_000);
	localparam int unsigned PT_DEPTH = 2000;
	localparam logic [10:0] PT_LAST = 11'h7cf;
	localparam logic [10:0] PT_MAX = 11'h7d0;
	localparam logic [8:0] RATE_MIN = 9'h005;
	localparam logic [8:0] RATE_1MS = 9'h005;
	localparam logic [10:0] RING_MIN = 11'h005;
	localparam logic [10:0] RING_MAX = 11'h054;
	localparam int unsigned VEL_MSB = 24;
	localparam int unsigned MASK_LSB = 28;
	localparam int unsigned POS_LSB = 32;
	localparam int unsigned FRAC_W = 16;
	// Register offsets of the command block
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_RUNARG = 8'h04;
	localparam logic [7:0] OFS_LOOPS = 8'h08;
	localparam logic [7:0] OFS_RATE = 8'h0c;
	localparam logic [7:0] OFS_PTIDX = 8'h10;
	localparam logic [7:0] OFS_PTPOS = 8'h14;
	localparam logic [7:0] OFS_PTVEL = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam int unsigned RUNARG_START_LSB = 16;
	localparam int unsigned ST_DEV_BUSY = 0;
	localparam int unsigned ST_SEQ_BUSY = 1;
	localparam int unsigned ST_PEND = 2;
	localparam int unsigned ST_RATE_SEEN = 3;
	localparam int unsigned ST_SEQ_ERR = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SCCI_OP_RATE, SCCI_OP_SCALE, SCCI_OP_RUN, SCCI_OP_OTHER} scci_op_t;

	function automatic logic scci_is_spline(input scci_op_t op);
		return op != SCCI_OP_OTHER;
	endfunction : scci_is_spline

	function automatic logic [31:0] scci_vel_ext(input logic [24:0] v);
		return {{7{v[VEL_MSB]}}, v};
	endfunction : scci_vel_ext
endpackage : scci_pkg

// [rtl/scci_if.sv]
// Purpose: Command and table link between sequencer and interpolator
// Assumes: Both ends on REF_CLK
// Notes: Command moves when cmd_valid and cmd_ready are both high
`timescale 1ns/1ps
interface scci_if;
	logic cmd_valid;
	logic cmd_ready;
	scci_pkg::scci_op_t cmd_op;
	logic [10:0] cmd_cnt;
	logic [10:0] cmd_start;
	logic [14:0] cmd_loops;
	logic [8:0] cmd_rate;
	logic pt_we;
	logic [10:0] pt_idx;
	logic [31:0] pt_pos;
	logic [31:0] pt_vel;
	logic busy;

	modport dev (input cmd_valid, cmd_op, cmd_cnt, cmd_start, cmd_loops, cmd_rate,
		pt_we, pt_idx, pt_pos, pt_vel, output cmd_ready, busy);
	modport host (output cmd_valid, cmd_op, cmd_cnt, cmd_start, cmd_loops, cmd_rate,
		pt_we, pt_idx, pt_pos, pt_vel, input cmd_ready, busy);
endinterface : scci_if

// [rtl/scci_host.sv]
// Purpose: Command sequencer with AXI4-Lite register block
// Assumes: One write and one read outstanding at most
// Notes: Writes to CMD while a command is pending are refused with SLVERR
// Contract
// - rate code 5..511, spacing code/5 ms
// - interpolate on fixed 200 us tick
// - point is 32-bit position plus velocity
// - velocity is 25-bit 8.16 two's complement
// - top four velocity bits are axis mask
// - axis mask decoded only in spline mode
// - run point count at most 2000
// - each point drives a single motor; the code drives every axis set in the point's 4-bit mask
// - fetching begins at run start index
// - repeat count up to 32767 passes
// - zero repeat count loops until stopped
// - run starts at once, 5 ms interpret
// - order: rate, optional scale, then run
// - points loaded before run command
// - spline commands held until motion ends
// - other commands proceed without waiting
// - rate setting kept until changed
// - 1 ms spacing keeps 5..84 points
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module scci_host #(
	parameter logic [17:0] INTERP_CYC = 18'(scci_pkg::INTERP_CYC)
) (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	scci_if.host lnk
);
	typedef enum logic [1:0] {SCCI_SQ_IDLE, SCCI_SQ_ISSUE, SCCI_SQ_INTERP} scci_sq_t;
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic aw_have;
		logic w_have;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] runarg;
		logic [14:0] loops;
		logic [8:0] rate;
		logic [10:0] pt_idx;
		logic [31:0] pt_pos;
		logic [31:0] pt_vel;
		logic pt_we;
		logic pend;
		scci_pkg::scci_op_t pend_op;
		logic rate_seen;
		logic seq_err;
		scci_sq_t sq;
		logic [17:0] wcnt;
		logic cvalid;
		scci_pkg::scci_op_t cop;
	} scci_host_st_t;

	scci_host_st_t s_r;
	scci_host_st_t s_nxt;

	function automatic logic [31:0] scci_wmerge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : scci_wmerge

	always_comb begin
		logic [31:0] rd;
		logic rd_ok;
		logic set_err;
		logic [10:0] cnt;
		rd = 32'h0000_0000;
		rd_ok = 1'b1;
		set_err = 1'b0;
		cnt = s_r.runarg[10:0];
		s_nxt = s_r;
		s_nxt.pt_we = 1'b0;
		if (s_r.bvalid && S_AXI_BREADY) begin
			s_nxt.bvalid = 1'b0;
		end
		if (S_AXI_AWVALID && s_r.awrdy) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s_r.wrdy) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = S_AXI_WDATA;
			s_nxt.w_strb = S_AXI_WSTRB;
		end
		if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = scci_pkg::RESP_OKAY;
			case (s_r.aw_addr)
				scci_pkg::OFS_CMD: begin
					if (s_r.pend) begin
						s_nxt.bresp = scci_pkg::RESP_SLVERR;
					end else begin
						s_nxt.pend = 1'b1;
						s_nxt.pend_op = scci_pkg::scci_op_t'(s_r.w_data[1:0]);
						if (scci_pkg::scci_op_t'(s_r.w_data[1:0]) == scci_pkg::SCCI_OP_RUN) begin
							// Run before any rate setting is flagged but still issued
							if (!s_r.rate_seen) begin
								set_err = 1'b1;
							end
							// Ring must hold 5 ms of points at the shortest spacing
							// Codes below the floor are clamped to 1 ms by the interpolator
							if (s_r.rate <= scci_pkg::RATE_1MS &&
									(cnt < scci_pkg::RING_MIN || cnt > scci_pkg::RING_MAX)) begin
								set_err = 1'b1;
							end
						end
					end
				end
				scci_pkg::OFS_RUNARG: s_nxt.runarg = scci_wmerge(s_r.runarg, s_r.w_data, s_r.w_strb);
				scci_pkg::OFS_LOOPS: s_nxt.loops = 15'(scci_wmerge(32'(s_r.loops), s_r.w_data,
					s_r.w_strb));
				scci_pkg::OFS_RATE: s_nxt.rate = 9'(scci_wmerge(32'(s_r.rate), s_r.w_data, s_r.w_strb));
				scci_pkg::OFS_PTIDX: s_nxt.pt_idx = 11'(scci_wmerge(32'(s_r.pt_idx), s_r.w_data,
					s_r.w_strb));
				scci_pkg::OFS_PTPOS: s_nxt.pt_pos = scci_wmerge(s_r.pt_pos, s_r.w_data, s_r.w_strb);
				scci_pkg::OFS_PTVEL: begin
					// Velocity write completes the eight-byte point and stores it
					s_nxt.pt_vel = scci_wmerge(s_r.pt_vel, s_r.w_data, s_r.w_strb);
					s_nxt.pt_we = 1'b1;
				end
				scci_pkg::OFS_STATUS: begin
					if (s_r.w_data[scci_pkg::ST_SEQ_ERR]) begin
						s_nxt.seq_err = 1'b0;
					end
				end
				default: s_nxt.bresp = scci_pkg::RESP_SLVERR;
			endcase
		end
		if (set_err) begin
			s_nxt.seq_err = 1'b1;
		end
		case (S_AXI_ARADDR)
			scci_pkg::OFS_CMD: rd = {30'h0, s_r.pend_op};
			scci_pkg::OFS_RUNARG: rd = s_r.runarg;
			scci_pkg::OFS_LOOPS: rd = 32'(s_r.loops);
			scci_pkg::OFS_RATE: rd = 32'(s_r.rate);
			scci_pkg::OFS_PTIDX: rd = 32'(s_r.pt_idx);
			scci_pkg::OFS_PTPOS: rd = s_r.pt_pos;
			scci_pkg::OFS_PTVEL: rd = s_r.pt_vel;
			scci_pkg::OFS_STATUS: begin
				rd[scci_pkg::ST_DEV_BUSY] = lnk.busy;
				rd[scci_pkg::ST_SEQ_BUSY] = s_r.sq != SCCI_SQ_IDLE;
				rd[scci_pkg::ST_PEND] = s_r.pend;
				rd[scci_pkg::ST_RATE_SEEN] = s_r.rate_seen;
				rd[scci_pkg::ST_SEQ_ERR] = s_r.seq_err;
			end
			default: rd_ok = 1'b0;
		endcase
		if (s_r.rvalid && S_AXI_RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s_r.arrdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd;
			s_nxt.rresp = rd_ok ? scci_pkg::RESP_OKAY : scci_pkg::RESP_SLVERR;
		end
		s_nxt.arrdy = !s_nxt.rvalid;
		s_nxt.awrdy = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wrdy = !s_nxt.w_have && !s_nxt.bvalid;
		case (s_r.sq)
			SCCI_SQ_IDLE: begin
				// Spline commands wait for motion to end, others go at once
				if (s_r.pend && (!scci_pkg::scci_is_spline(s_r.pend_op) || !lnk.busy)) begin
					s_nxt.cvalid = 1'b1;
					s_nxt.cop = s_r.pend_op;
					s_nxt.sq = SCCI_SQ_ISSUE;
				end
			end
			SCCI_SQ_ISSUE: begin
				if (lnk.cmd_ready) begin
					s_nxt.cvalid = 1'b0;
					s_nxt.pend = 1'b0;
					s_nxt.wcnt = 18'h00000;
					if (s_r.cop == scci_pkg::SCCI_OP_RATE) begin
						s_nxt.rate_seen = 1'b1;
					end
					s_nxt.sq = (s_r.cop == scci_pkg::SCCI_OP_RUN) ? SCCI_SQ_INTERP : SCCI_SQ_IDLE;
				end
			end
			SCCI_SQ_INTERP: begin
				// Interpretation time of a run before the next line
				s_nxt.wcnt = s_r.wcnt + 18'h00001;
				if (s_r.wcnt >= INTERP_CYC - 18'h00001) begin
					s_nxt.sq = SCCI_SQ_IDLE;
				end
			end
			default: s_nxt.sq = SCCI_SQ_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s_r <= '0;
			s_r.rate <= scci_pkg::RATE_MIN;
			s_r.awrdy <= 1'b1;
			s_r.wrdy <= 1'b1;
			s_r.arrdy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign S_AXI_AWREADY = s_r.awrdy;
	assign S_AXI_WREADY = s_r.wrdy;
	assign S_AXI_BVALID = s_r.bvalid;
	assign S_AXI_BRESP = s_r.bresp;
	assign S_AXI_ARREADY = s_r.arrdy;
	assign S_AXI_RVALID = s_r.rvalid;
	assign S_AXI_RDATA = s_r.rdata;
	assign S_AXI_RRESP = s_r.rresp;
	assign lnk.cmd_valid = s_r.cvalid;
	assign lnk.cmd_op = s_r.cop;
	assign lnk.cmd_cnt = s_r.runarg[10:0];
	assign lnk.cmd_start = s_r.runarg[scci_pkg::RUNARG_START_LSB +: 11];
	assign lnk.cmd_loops = s_r.loops;
	assign lnk.cmd_rate = s_r.rate;
	assign lnk.pt_we = s_r.pt_we;
	assign lnk.pt_idx = s_r.pt_idx;
	assign lnk.pt_pos = s_r.pt_pos;
	assign lnk.pt_vel = s_r.pt_vel;
endmodule : scci_host

// [rtl/scci_dev.sv]
// Purpose: Cubic spline point table and 200 us command interpolator
// Assumes: Sequencer keeps spline commands back while BUSY is high
// Notes: Position is integrated from the point velocity and snapped at each point
`timescale 1ns/1ps
module scci_dev #(
	parameter logic [15:0] TICK_CYC = 16'(scci_pkg::TICK_CYC)
) (
	input wire logic REF_CLK,
	input wire logic RST_B,
	scci_if.dev lnk,
	input wire logic MODE_SPLINE,
	input wire logic STOP,
	output logic [31:0] CMD_POS,
	output logic [31:0] CMD_VEL,
	output logic [3:0] AXIS_MASK,
	output logic TICK,
	output logic BUSY
);
	typedef enum logic {SCCI_D_IDLE, SCCI_D_RUN} scci_dst_t;
	typedef struct packed {
		logic [scci_pkg::PT_DEPTH-1:0][63:0] tbl;
		scci_dst_t st;
		logic rdy;
		logic [15:0] tcnt;
		logic [8:0] rate;
		logic [8:0] seg;
		logic [10:0] idx;
		logic [10:0] start;
		logic [10:0] cnt;
		logic [10:0] left;
		logic [14:0] loops;
		logic inf;
		logic [47:0] acc;
		logic [24:0] vel;
		logic [3:0] mask;
		logic [3:0] omask;
		logic tick;
	} scci_dev_st_t;

	scci_dev_st_t s_r;
	scci_dev_st_t s_nxt;

	function automatic logic [10:0] scci_idx_inc(input logic [10:0] i);
		return (i == scci_pkg::PT_LAST) ? 11'h000 : i + 11'h001;
	endfunction : scci_idx_inc

	always_comb begin
		logic load;
		logic [10:0] load_idx;
		logic [63:0] e;
		load = 1'b0;
		load_idx = s_r.idx;
		e = 64'h0000_0000_0000_0000;
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (lnk.pt_we && lnk.pt_idx < scci_pkg::PT_MAX) begin
			s_nxt.tbl[lnk.pt_idx] = {lnk.pt_pos, lnk.pt_vel};
		end
		case (s_r.st)
			SCCI_D_IDLE: begin
				s_nxt.tcnt = 16'h0000;
			end
			SCCI_D_RUN: begin
				// Tick runs independent of the point spacing
				s_nxt.tcnt = s_r.tcnt + 16'h0001;
				if (s_r.tcnt >= TICK_CYC - 16'h0001) begin
					s_nxt.tcnt = 16'h0000;
					s_nxt.tick = 1'b1;
					s_nxt.acc = s_r.acc + {{23{s_r.vel[scci_pkg::VEL_MSB]}}, s_r.vel};
					s_nxt.seg = s_r.seg + 9'h001;
					// Rate code counts ticks per interval directly
					if (s_r.seg >= s_r.rate - 9'h001) begin
						s_nxt.seg = 9'h000;
						load = 1'b1;
						if (s_r.left == 11'h001) begin
							if (!s_r.inf && s_r.loops <= 15'h0001) begin
								load = 1'b0;
								s_nxt.st = SCCI_D_IDLE;
							end else begin
								// Pass done: rewind and count it unless endless
								load_idx = s_r.start;
								s_nxt.left = s_r.cnt;
								if (!s_r.inf) begin
									s_nxt.loops = s_r.loops - 15'h0001;
								end
							end
						end else begin
							load_idx = scci_idx_inc(s_r.idx);
							s_nxt.left = s_r.left - 11'h001;
						end
					end
				end
			end
			default: s_nxt.st = SCCI_D_IDLE;
		endcase
		if (lnk.cmd_valid && s_r.rdy) begin
			case (lnk.cmd_op)
				scci_pkg::SCCI_OP_RATE: begin
					// Codes below the floor clamp up; 9 bits cap at 511
					s_nxt.rate = (lnk.cmd_rate < scci_pkg::RATE_MIN) ? scci_pkg::RATE_MIN
						: lnk.cmd_rate;
				end
				scci_pkg::SCCI_OP_RUN: begin
					// Empty, oversize or out-of-table runs are dropped silently
					if (lnk.cmd_cnt != 11'h000 && lnk.cmd_cnt <= scci_pkg::PT_MAX &&
							lnk.cmd_start < scci_pkg::PT_MAX) begin
						s_nxt.st = SCCI_D_RUN;
						s_nxt.start = lnk.cmd_start;
						s_nxt.cnt = lnk.cmd_cnt;
						s_nxt.left = lnk.cmd_cnt;
						s_nxt.loops = lnk.cmd_loops;
						s_nxt.inf = lnk.cmd_loops == 15'h0000;
						s_nxt.seg = 9'h000;
						s_nxt.tcnt = 16'h0000;
						load = 1'b1;
						load_idx = lnk.cmd_start;
					end
				end
				default: begin
				end
			endcase
		end
		if (STOP) begin
			s_nxt.st = SCCI_D_IDLE;
			load = 1'b0;
		end
		if (load) begin
			// One point carries one position and velocity for every axis set in its mask
			e = s_r.tbl[load_idx];
			s_nxt.idx = load_idx;
			s_nxt.acc = {e[scci_pkg::POS_LSB +: 32], {scci_pkg::FRAC_W{1'b0}}};
			s_nxt.vel = e[scci_pkg::VEL_MSB:0];
			s_nxt.mask = e[scci_pkg::MASK_LSB +: 4];
		end
		// Registered so the pin comes from a flop; follows the mode one cycle late
		s_nxt.omask = MODE_SPLINE ? s_nxt.mask : 4'h0;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s_r <= '0;
			s_r.rate <= scci_pkg::RATE_MIN;
			s_r.rdy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.cmd_ready = s_r.rdy;
	assign lnk.busy = s_r.st == SCCI_D_RUN;
	assign BUSY = s_r.st == SCCI_D_RUN;
	assign CMD_POS = s_r.acc[47:16];
	assign CMD_VEL = scci_pkg::scci_vel_ext(s_r.vel);
	assign AXIS_MASK = s_r.omask;
	assign TICK = s_r.tick;
endmodule : scci_dev

// [tb/scci_chk.sv]
// Purpose: Link checker between sequencer and interpolator
// Assumes: One clock, RST_B synchronous active low
// Notes: Windows sized for the short tick and wait counts of the bench
`timescale 1ns/1ps
module scci_chk (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire scci_pkg::scci_op_t cmd_op,
	input wire logic [10:0] cmd_cnt,
	input wire logic [10:0] cmd_start,
	input wire logic pt_we,
	input wire logic busy
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	property p_rdy; cmd_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("cmd_ready low");
	property p_one; cmd_valid |=> !cmd_valid; endproperty
	a_one: assert property (p_one) else $error("command held twice");
	property p_hold; cmd_valid && busy |-> cmd_op == scci_pkg::SCCI_OP_OTHER; endproperty
	a_hold: assert property (p_hold) else $error("spline command during motion");
	property p_start;
		cmd_valid && cmd_op == scci_pkg::SCCI_OP_RUN && cmd_cnt != 11'h000
			&& cmd_cnt <= scci_pkg::PT_MAX && cmd_start < scci_pkg::PT_MAX |=> busy;
	endproperty
	a_start: assert property (p_start) else $error("run did not start");
	property p_big;
		cmd_valid && cmd_op == scci_pkg::SCCI_OP_RUN && cmd_cnt > scci_pkg::PT_MAX
			&& !busy |=> !busy;
	endproperty
	a_big: assert property (p_big) else $error("oversized run started");
	property p_gap; cmd_valid && cmd_op == scci_pkg::SCCI_OP_RUN |=> !cmd_valid [*8]; endproperty
	a_gap: assert property (p_gap) else $error("command inside interpret wait");
	property p_we; pt_we |=> !pt_we; endproperty
	a_we: assert property (p_we) else $error("point store not a pulse");
	property p_min; $rose(busy) |-> busy [*8]; endproperty
	a_min: assert property (p_min) else $error("motion shorter than an interval");
endmodule : scci_chk

// [tb/tb.sv]
// Purpose: Self-checking bench for sequencer and interpolator pair
// Assumes: Tick of 10 cycles, interpret wait of 16 cycles
// Notes: Tick counts equal the effective rate code (codes below 5 clamp to 5) times points times passes
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic [7:0] a; logic [31:0] d;} scci_row_t;
	logic ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, mode, stop;
	logic awready, wready, bvalid, arready, rvalid, tick, busy;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pos, vel;
	logic [3:0] wstrb, mask;
	logic [1:0] bresp, rresp;
	int err_count, comparisons;
	scci_row_t rows[4] = '{'{scci_pkg::OFS_RATE, 32'h19}, '{scci_pkg::OFS_LOOPS, 32'h7fff},
		'{scci_pkg::OFS_RUNARG, 32'h07cf_07d0}, '{scci_pkg::OFS_PTIDX, 32'h7cf}};

	scci_if lnk ();
	scci_host #(.INTERP_CYC(18'h00010)) scci_host_i (.REF_CLK(ref_clk), .RST_B(rst_b),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .lnk(lnk));
	scci_dev #(.TICK_CYC(16'h000a)) scci_dev_i (.REF_CLK(ref_clk), .RST_B(rst_b), .lnk(lnk),
		.MODE_SPLINE(mode), .STOP(stop), .CMD_POS(pos), .CMD_VEL(vel), .AXIS_MASK(mask),
		.TICK(tick), .BUSY(busy));
	scci_chk scci_chk_i (.REF_CLK(ref_clk), .RST_B(rst_b), .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .cmd_op(lnk.cmd_op), .cmd_cnt(lnk.cmd_cnt),
		.cmd_start(lnk.cmd_start), .pt_we(lnk.pt_we), .busy(lnk.busy));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// Each bus task starts one edge later so no signal is assigned twice in a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic wok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'(scci_pkg::RESP_OKAY), 32'(r));
	endtask : wok

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(n, e, d & m);
	endtask : rchk

	task automatic pt(input logic [10:0] i, input logic [31:0] p, input logic [31:0] v);
		wok(scci_pkg::OFS_PTIDX, 32'(i));
		wok(scci_pkg::OFS_PTPOS, p);
		wok(scci_pkg::OFS_PTVEL, v);
	endtask : pt

	task automatic waitb;
		while (busy !== 1'b1) @(posedge ref_clk);
	endtask : waitb

	// Counts ticks to the end of motion; the tick 10 and 17 samples occur only in the first run, pos_mid in every run
	task automatic tk(output int n);
		n = 0;
		while (busy === 1'b1) begin
			@(posedge ref_clk);
			if (tick === 1'b1) begin
				n++;
				if (n == 3) chk("pos_mid", 32'h1001, pos);
				if (n == 10) chk("vel_p2", 32'hfff8_0000, vel);
				if (n == 10) chk("mask_p2", 32'h9, 32'(mask));
				if (n == 17) chk("vel_wrap", 32'h8000, vel);
			end
		end
	endtask : tk

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		{rst_b, awvalid, wvalid, bready, arvalid, rready, mode, stop} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		cyc(3);
		rst_b <= 1'b1;
		rchk("rate_rst", scci_pkg::OFS_RATE, 32'h1ff, 32'h5);
		rchk("status_rst", scci_pkg::OFS_STATUS, 32'h1f, 32'h0);
		wok(scci_pkg::OFS_CMD, 32'h2);
		rchk("run_early", scci_pkg::OFS_STATUS, 32'h18, 32'h10);
		wok(scci_pkg::OFS_STATUS, 32'h10);
		rchk("err_clear", scci_pkg::OFS_STATUS, 32'h10, 32'h0);
		foreach (rows[i]) begin
			wok(rows[i].a, rows[i].d);
			rchk("row", rows[i].a, 32'hffff_ffff, rows[i].d);
		end
		rd(8'h20, d, r);
		chk("unmapped", 32'(scci_pkg::RESP_SLVERR), 32'(r));
		pt(11'h3, 32'h1000, 32'h3000_8000);
		pt(11'h4, 32'h2000, 32'h9ff8_0000);
		mode <= 1'b1;
		wok(scci_pkg::OFS_RATE, 32'h7);
		wok(scci_pkg::OFS_CMD, 32'h0);
		wok(scci_pkg::OFS_CMD, 32'h1);
		wok(scci_pkg::OFS_RUNARG, 32'h0003_0002);
		wok(scci_pkg::OFS_LOOPS, 32'h2);
		wok(scci_pkg::OFS_CMD, 32'h2);
		waitb();
		chk("pos", 32'h1000, pos);
		chk("vel", 32'h8000, vel);
		chk("mask", 32'h3, 32'(mask));
		mode <= 1'b0;
		cyc(2);
		chk("mask_off", 32'h0, 32'(mask));
		mode <= 1'b1;
		tk(n);
		chk("ticks", 32'd28, 32'(n));
		wok(scci_pkg::OFS_RUNARG, 32'h0004_0001);
		wok(scci_pkg::OFS_LOOPS, 32'h0);
		wok(scci_pkg::OFS_CMD, 32'h2);
		waitb();
		wok(scci_pkg::OFS_CMD, 32'h3);
		cyc(40);
		rchk("st_other", scci_pkg::OFS_STATUS, 32'h5, 32'h1);
		wok(scci_pkg::OFS_CMD, 32'h0);
		cyc(40);
		rchk("st_held", scci_pkg::OFS_STATUS, 32'h5, 32'h5);
		wr(scci_pkg::OFS_CMD, 32'h2, r);
		chk("refuse", 32'(scci_pkg::RESP_SLVERR), 32'(r));
		cyc(200);
		chk("endless", 32'h1, 32'(busy));
		stop <= 1'b1;
		cyc(1);
		stop <= 1'b0;
		cyc(3);
		chk("stopped", 32'h0, 32'(busy));
		cyc(40);
		rchk("st_drain", scci_pkg::OFS_STATUS, 32'h5, 32'h0);
		wok(scci_pkg::OFS_RUNARG, 32'h0000_07d1);
		wok(scci_pkg::OFS_CMD, 32'h2);
		cyc(40);
		chk("cnt_over", 32'h0, 32'(busy));
		wok(scci_pkg::OFS_RUNARG, 32'h0003_0001);
		wok(scci_pkg::OFS_LOOPS, 32'h1);
		wok(scci_pkg::OFS_CMD, 32'h2);
		waitb();
		tk(n);
		chk("kept_rate", 32'd7, 32'(n));
		wok(scci_pkg::OFS_RATE, 32'h2);
		wok(scci_pkg::OFS_CMD, 32'h0);
		wok(scci_pkg::OFS_CMD, 32'h2);
		waitb();
		tk(n);
		chk("rate_clamp", 32'd5, 32'(n));
		rchk("st_ring", scci_pkg::OFS_STATUS, 32'h18, 32'h18);
		end_sim();
	end

	// Whole run is about a thousand cycles; this limit of 10000 cycles only cuts a hang
	initial begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule : tb
